// *** design/isl_params.svh ***
// Constants for the instruction slotting stage.
// Assumes inclusion by bare name from the block's design files.
`ifndef ISL_PARAMS_SVH
`define ISL_PARAMS_SVH

`define ISL_SLOTS     4
`define ISL_REG_W     5
`define ISL_CNT_W     3
`define ISL_ZERO_REG  5'h1f
`define ISL_SPLIT_CNT 3'h2

`endif

// *** design/isl_pkg.sv ***
// Types shared by the slotting stage: instruction classes, pipes, states.
// Assumes the decoder supplies one class code per fetch-group slot.
package isl_pkg;

   typedef enum logic [4:0] {
      CLS_LOAD, CLS_MEMWR, CLS_BARRIER, CLS_RMF, CLS_PRMOVE, CLS_ICBR,
      CLS_FCBR, CLS_JUMP, CLS_IARITH, CLS_ILOGIC, CLS_SIGN_EXTEND_CLASS, CLS_SHIFT,
      CLS_CMOVE, CLS_INT_COMPARE_CLASS, CLS_LMULT, CLS_QMULT, CLS_HMULT, CLS_MEDIA,
      CLS_FOP, CLS_FP_DIVIDE_CLASS, CLS_FMULT, CLS_FCOPY, CLS_MISC, CLS_NULLOP
   } isl_class_t;

   typedef enum logic [2:0] {
      PIPE_NONE, PIPE_INT_A, PIPE_INT_B, PIPE_FP_ADD, PIPE_FP_MULT
   } isl_pipe_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SLOT = 2'h1,
      ST_WAIT = 2'h3
   } isl_state_t;

   typedef struct packed {
      logic fm;
      logic fa;
      logic b;
      logic a;
   } isl_elig_t;

endpackage

// *** design/isl_class_if.sv ***
// Per-slot classification results passed from the classifier to its users.
// Assumes one producer and any number of consumers on the same clock.
`timescale 1ns/1ps
`include "isl_params.svh"
interface isl_class_if;
   import isl_pkg::*;
   isl_elig_t              elig [`ISL_SLOTS];
   logic [`ISL_SLOTS-1:0]  intI;
   logic [`ISL_SLOTS-1:0]  fpF;
   logic [`ISL_SLOTS-1:0]  aOnly;
   logic [`ISL_SLOTS-1:0]  isLd;
   logic [`ISL_SLOTS-1:0]  isSt;
   logic [`ISL_SLOTS-1:0]  isCbr;
   logic [`ISL_SLOTS-1:0]  isJmp;
   logic [`ISL_SLOTS-1:0]  isNull;

   modport prod (output elig, intI, fpF, aOnly, isLd, isSt, isCbr, isJmp, isNull);
   modport cons (input  elig, intI, fpF, aOnly, isLd, isSt, isCbr, isJmp, isNull);
endinterface // isl_class_if

// *** design/isl_classify.sv ***
// Maps each slot's class code to the pipes it may use and its special flags.
// Assumes class, register-select and destination are stable in the group store.
`timescale 1ns/1ps
`include "isl_params.svh"
module isl_classify import isl_pkg::*; (
   // Group contents
   input wire isl_class_t            cls    [`ISL_SLOTS],
   input wire logic [`ISL_SLOTS-1:0] iprB,
   input wire logic [`ISL_SLOTS-1:0] unalQ,
   input wire logic [`ISL_REG_W-1:0] dest   [`ISL_SLOTS],
   // Classification
   isl_class_if.prod                 ci
);

   function automatic isl_elig_t elig_of(input isl_class_t c, input logic selB);
      isl_elig_t e;
      e = '0;
      case (c)
         CLS_LOAD, CLS_IARITH, CLS_ILOGIC, CLS_CMOVE, CLS_INT_COMPARE_CLASS: begin
            e.a = 1'b1;
            e.b = 1'b1;
         end
         CLS_MEMWR, CLS_BARRIER, CLS_RMF, CLS_SIGN_EXTEND_CLASS, CLS_SHIFT, CLS_LMULT,
         CLS_QMULT, CLS_HMULT, CLS_MEDIA, CLS_MISC: e.a = 1'b1;
         CLS_PRMOVE: begin
            e.a = ~selB;
            e.b = selB;
         end
         CLS_ICBR, CLS_JUMP: e.b = 1'b1;
         CLS_FOP, CLS_FP_DIVIDE_CLASS, CLS_FCBR: e.fa = 1'b1;
         CLS_FMULT: e.fm = 1'b1;
         CLS_FCOPY: begin
            e.fa = 1'b1;
            e.fm = 1'b1;
         end
         default: e = '0;
      endcase
      return e;
   endfunction

   generate
      for (genvar s = 0; s < `ISL_SLOTS; s++) begin : gSlot
         logic nullOp;
         isl_elig_t e;
         // Unaligned quadword load into the zero register needs no pipe
         assign nullOp = (cls[s] == CLS_NULLOP) ||
                         (cls[s] == CLS_LOAD && unalQ[s] && dest[s] == `ISL_ZERO_REG);
         assign e            = nullOp ? '0 : elig_of(cls[s], iprB[s]);
         assign ci.elig[s]   = e;
         assign ci.isNull[s] = nullOp;
         assign ci.intI[s]   = (e.a | e.b) & ~(e.fa | e.fm);
         assign ci.fpF[s]    = e.fa | e.fm;
         assign ci.aOnly[s]  = e.a & ~e.b;
         assign ci.isLd[s]   = (cls[s] == CLS_LOAD) && !nullOp;
         assign ci.isSt[s]   = (cls[s] == CLS_MEMWR);
         assign ci.isCbr[s]  = (cls[s] == CLS_ICBR) || (cls[s] == CLS_FCBR);
         assign ci.isJmp[s]  = (cls[s] == CLS_JUMP);
      end
   endgenerate

endmodule // isl_classify

// *** design/isl_arrange.sv ***
// Detects the two integer/float arrangements that cap the first slotted set at two.
// Assumes the valid mask and classification describe the whole fetch group.
`timescale 1ns/1ps
`include "isl_params.svh"
module isl_arrange import isl_pkg::*; (
   // Group shape
   input  wire logic [`ISL_SLOTS-1:0] valid,
   isl_class_if.cons                  ci,
   // Detection
   output logic                       hit
);

   logic ifii;
   logic fii;

   // I,F,I,I over the full group
   assign ifii = (valid == 4'hf) && ci.intI[0] && ci.fpF[1] && ci.intI[2] && ci.intI[3];
   // F,I,I at the start of the group
   assign fii  = (valid[2:0] == 3'h7) && ci.fpF[0] && ci.intI[1] && ci.intI[2];
   assign hit  = ifii || fii;

endmodule // isl_arrange

// *** design/isl_slotter.sv ***
// Slotting stage: takes an aligned four-instruction fetch group, assigns
// instructions in order to two integer and two floating pipes, and forwards
// each slotted set to the issue check.
// Assumes the buffer holds a group until grpReady, and the issue stage
// reports issued instructions in program order, one pulse per instruction.
//
// How it works
// - Loads use either integer pipe, stores pipe A
// - Barrier, shift, multiply, media, misc: pipe A
// - Register moves pick pipe by register selected
// - Integer branches and jumps go to pipe B only
// - Simple integer classes use either integer pipe
// - Float operate, divide, branch: add pipe
// - Float multiply to mult pipe; copy either
// - Unaligned load to zero register needs none
// - Start with lowest valid instruction in group
// - Dual integer prefers A, B on conflict
// - Dual float prefers add pipe, else multiply
// - Mark pipe taken; stop when none fits
// - Never forward out of program order
// - Forwarded set free of static pipe conflicts
// - Load and store never share a set
// - Drop everything after taken branch or jump
// - No second branch after not-taken branch
// - Detect I,F,I,I and leading F,I,I
// - Such groups cap the first set at two
// - Hold later instructions until stalled one issues
// - Grouping changes timing only, never results
`timescale 1ns/1ps
`include "isl_params.svh"
module isl_slotter import isl_pkg::*; (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // Fetch group from the instruction buffer
   input  wire logic                  grpValid,
   input  wire logic [`ISL_SLOTS-1:0] slotValid,
   input  wire isl_class_t            slotClass  [`ISL_SLOTS],
   input  wire logic [`ISL_SLOTS-1:0] slotPredTaken,
   input  wire logic [`ISL_SLOTS-1:0] slotIprPipeB,
   input  wire logic [`ISL_SLOTS-1:0] slotUnalignedQ,
   input  wire logic [`ISL_REG_W-1:0] slotDestReg [`ISL_SLOTS],
   output logic                       grpReady,
   // Slotted set toward the issue check
   output logic [`ISL_SLOTS-1:0]      fwdValid,
   output isl_pipe_t                  fwdPipe    [`ISL_SLOTS],
   input  wire logic [`ISL_SLOTS-1:0] issIssued
);

   isl_state_t             state_reg;
   isl_state_t             state_next;
   logic                   grpReady_reg;
   logic [`ISL_SLOTS-1:0]  grpMask_reg;
   isl_class_t             cls_reg    [`ISL_SLOTS];
   logic [`ISL_SLOTS-1:0]  predTaken_reg;
   logic [`ISL_SLOTS-1:0]  iprB_reg;
   logic [`ISL_SLOTS-1:0]  unalQ_reg;
   logic [`ISL_REG_W-1:0]  dest_reg   [`ISL_SLOTS];
   logic [`ISL_SLOTS-1:0]  grpAll_reg;
   logic                   firstPass_reg;
   logic [`ISL_SLOTS-1:0]  fwdMask_reg;
   isl_pipe_t              fwdPipe_reg [`ISL_SLOTS];

   logic [`ISL_SLOTS-1:0]  takeMask;
   logic [`ISL_SLOTS-1:0]  dropMask;
   isl_pipe_t              pipeSel    [`ISL_SLOTS];
   logic [`ISL_SLOTS-1:0]  fwdLeft;
   logic                   arrHit;
   logic                   accept;

   isl_class_if ci ();

   isl_classify uClassify (
      .cls   (cls_reg),
      .iprB  (iprB_reg),
      .unalQ (unalQ_reg),
      .dest  (dest_reg),
      .ci    (ci.prod)
   );

   // Shape is judged on the group as fetched, not on what remains
   isl_arrange uArrange (
      .valid (grpAll_reg),
      .ci    (ci.cons),
      .hit   (arrHit)
   );

   assign accept  = grpValid && grpReady_reg;
   assign fwdLeft = fwdMask_reg & ~issIssued;

   // Is the next integer instruction after slot i restricted to pipe A?
   function automatic logic next_int_a_only(input int                    i,
                                            input logic [`ISL_SLOTS-1:0] mask,
                                            input logic [`ISL_SLOTS-1:0] intI,
                                            input logic [`ISL_SLOTS-1:0] aOnly);
      logic found;
      logic res;
      found = 1'b0;
      res   = 1'b0;
      for (int j = i + 1; j < `ISL_SLOTS; j++) begin
         if (mask[j] && intI[j] && !found) begin
            found = 1'b1;
            res   = aOnly[j];
         end
      end
      return res;
   endfunction

   // Pipe for one instruction, given the pipes already taken in this set
   function automatic isl_pipe_t pick_pipe(input isl_elig_t e,
                                           input logic      takA,
                                           input logic      takB,
                                           input logic      takFa,
                                           input logic      takFm,
                                           input logic      nextA);
      isl_pipe_t p;
      p = PIPE_NONE;
      if (e.a && e.b) begin
         if (!takB && (takA || nextA)) begin
            p = PIPE_INT_B;
         end else if (!takA) begin
            p = PIPE_INT_A;
         end
      end else if (e.a) begin
         if (!takA) p = PIPE_INT_A;
      end else if (e.b) begin
         if (!takB) p = PIPE_INT_B;
      end else if (e.fa && e.fm) begin
         if (!takFa) begin
            p = PIPE_FP_ADD;
         end else if (!takFm) begin
            p = PIPE_FP_MULT;
         end
      end else if (e.fa) begin
         if (!takFa) p = PIPE_FP_ADD;
      end else if (e.fm) begin
         if (!takFm) p = PIPE_FP_MULT;
      end
      return p;
   endfunction

   // In-order pipe assignment over the stored group
   always_comb begin
      logic       takA;
      logic       takB;
      logic       takFa;
      logic       takFm;
      logic       stop;
      logic       cut;
      logic       sawLd;
      logic       sawSt;
      logic       sawBr;
      logic       nextA;
      logic       block;
      logic [`ISL_CNT_W-1:0] cnt;
      isl_pipe_t  pick;
      isl_elig_t  e;
      takA  = 1'b0;
      takB  = 1'b0;
      takFa = 1'b0;
      takFm = 1'b0;
      stop  = 1'b0;
      cut   = 1'b0;
      sawLd = 1'b0;
      sawSt = 1'b0;
      sawBr = 1'b0;
      nextA = 1'b0;
      block = 1'b0;
      cnt   = '0;
      pick  = PIPE_NONE;
      e     = '0;
      takeMask = '0;
      dropMask = '0;
      for (int i = 0; i < `ISL_SLOTS; i++) begin
         pipeSel[i] = PIPE_NONE;
      end
      // Walk from the lowest address upward
      for (int i = 0; i < `ISL_SLOTS; i++) begin
         pick = PIPE_NONE;
         e    = ci.elig[i];
         if (grpMask_reg[i] && cut) begin
            dropMask[i] = 1'b1;
         end else if (grpMask_reg[i] && !stop) begin
            nextA = next_int_a_only(i, grpMask_reg, ci.intI, ci.aOnly);
            block = (firstPass_reg && arrHit && cnt == `ISL_SPLIT_CNT)
                 || (ci.isLd[i] && sawSt) || (ci.isSt[i] && sawLd)
                 || ((ci.isCbr[i] || ci.isJmp[i]) && sawBr);
            if (!block && !ci.isNull[i]) begin
               pick = pick_pipe(e, takA, takB, takFa, takFm, nextA);
            end
            // Later instructions wait behind a refused one
            if (block || (pick == PIPE_NONE && !ci.isNull[i])) begin
               stop = 1'b1;
            end else begin
               takeMask[i] = 1'b1;
               pipeSel[i]  = pick;
               cnt         = cnt + 3'h1;
               takA  = takA  || (pick == PIPE_INT_A);
               takB  = takB  || (pick == PIPE_INT_B);
               takFa = takFa || (pick == PIPE_FP_ADD);
               takFm = takFm || (pick == PIPE_FP_MULT);
               sawLd = sawLd || ci.isLd[i];
               sawSt = sawSt || ci.isSt[i];
               if (ci.isJmp[i] || (ci.isCbr[i] && predTaken_reg[i])) begin
                  cut = 1'b1;
               end else if (ci.isCbr[i]) begin
                  sawBr = 1'b1;
               end
            end
         end
      end
   end

   // Sequencing: a new set is slotted only once the last one fully issued
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (accept) state_next = ST_SLOT;
         end
         ST_SLOT: state_next = ST_WAIT;
         ST_WAIT: begin
            if (fwdLeft == '0) begin
               state_next = (grpMask_reg == '0) ? ST_IDLE : ST_SLOT;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // Ready only when idle: a half-issued group must never be overwritten
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg    <= ST_IDLE;
         grpReady_reg <= 1'b1;
      end else begin
         state_reg    <= state_next;
         grpReady_reg <= (state_next == ST_IDLE);
      end
   end

   // Group store: loaded on accept, shrinks as sets are slotted or dropped
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         grpMask_reg   <= '0;
         grpAll_reg    <= '0;
         predTaken_reg <= '0;
         iprB_reg      <= '0;
         unalQ_reg     <= '0;
         firstPass_reg <= 1'b0;
         for (int i = 0; i < `ISL_SLOTS; i++) begin
            cls_reg[i]  <= CLS_NULLOP;
            dest_reg[i] <= '0;
         end
      end else if (state_reg == ST_IDLE && accept) begin
         grpMask_reg   <= slotValid;
         grpAll_reg    <= slotValid;
         predTaken_reg <= slotPredTaken;
         iprB_reg      <= slotIprPipeB;
         unalQ_reg     <= slotUnalignedQ;
         firstPass_reg <= 1'b1;
         for (int i = 0; i < `ISL_SLOTS; i++) begin
            cls_reg[i]  <= slotClass[i];
            dest_reg[i] <= slotDestReg[i];
         end
      end else if (state_reg == ST_SLOT) begin
         grpMask_reg   <= grpMask_reg & ~takeMask & ~dropMask;
         firstPass_reg <= 1'b0;
      end
   end

   // Forwarded set: stands until every member has issued
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fwdMask_reg <= '0;
         for (int i = 0; i < `ISL_SLOTS; i++) begin
            fwdPipe_reg[i] <= PIPE_NONE;
         end
      end else if (state_reg == ST_SLOT) begin
         fwdMask_reg <= takeMask;
         for (int i = 0; i < `ISL_SLOTS; i++) begin
            fwdPipe_reg[i] <= pipeSel[i];
         end
      end else begin
         fwdMask_reg <= fwdLeft;
         // Issued slots show no pipe, so stale choices never linger
         for (int i = 0; i < `ISL_SLOTS; i++) begin
            if (issIssued[i]) fwdPipe_reg[i] <= PIPE_NONE;
         end
      end
   end

   // Only timing depends on grouping; order and content pass unchanged
   assign grpReady = grpReady_reg;
   assign fwdValid = fwdMask_reg;

   generate
      for (genvar s = 0; s < `ISL_SLOTS; s++) begin : gOut
         assign fwdPipe[s] = fwdPipe_reg[s];
      end
   endgenerate

endmodule // isl_slotter

// *** verification/isl_issue_model.sv ***
// Issue-stage model: issues forwarded instructions strictly in program order.
// Assumes fwdValid from the slotting stage; slow mode issues one per two cycles.
`timescale 1ns/1ps
`include "isl_params.svh"
module isl_issue_model (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // Pace
   input  wire logic                  slowIss,
   // Slotted set and issue pulses
   input  wire logic [`ISL_SLOTS-1:0] fwdValid,
   output logic      [`ISL_SLOTS-1:0] issIssued
);
   logic [`ISL_SLOTS-1:0] pend;
   logic                  tick_reg;

   // Bits already pulsed are still shown for one edge; never pulse them twice
   assign pend = fwdValid & ~issIssued;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         issIssued <= '0;
         tick_reg  <= 1'b0;
      end else begin
         tick_reg  <= ~tick_reg;
         issIssued <= !slowIss ? pend : (tick_reg ? (pend & (~pend + 4'h1)) : 4'h0);
      end
   end
endmodule // isl_issue_model

// *** verification/isl_slotter_monitor.sv ***
// Checker for the slotting stage: pipe exclusivity and forward/issue handshake.
// Assumes it is bound to isl_slotter and sees only that module's ports.
`timescale 1ns/1ps
`include "isl_params.svh"
module isl_slotter_monitor import isl_pkg::*; (
   // Clock and reset
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   // Group handshake
   input wire logic                  grpValid,
   input wire logic [`ISL_SLOTS-1:0] slotValid,
   input wire logic                  grpReady,
   // Forwarded set
   input wire logic [`ISL_SLOTS-1:0] fwdValid,
   input wire isl_pipe_t             fwdPipe [`ISL_SLOTS],
   input wire logic [`ISL_SLOTS-1:0] issIssued
);
   logic [`ISL_SLOTS-1:0] onPipe [5];
   logic [`ISL_SLOTS-1:0] grpMask_reg;

   always_comb begin
      for (int p = 0; p < 5; p++) begin
         for (int i = 0; i < `ISL_SLOTS; i++) begin
            onPipe[p][i] = fwdValid[i] && (fwdPipe[i] == isl_pipe_t'(p));
         end
      end
   end

   // Slots of the accepted group; nothing else may ever be forwarded
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         grpMask_reg <= '0;
      end else if (grpValid && grpReady) begin
         grpMask_reg <= slotValid;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   intA_once_a: assert property ($onehot0(onPipe[PIPE_INT_A]))
      else $error("int pipe A given twice");
   intB_once_a: assert property ($onehot0(onPipe[PIPE_INT_B]))
      else $error("int pipe B given twice");
   fpAdd_once_a: assert property ($onehot0(onPipe[PIPE_FP_ADD]))
      else $error("fp add pipe given twice");
   fpMult_once_a: assert property ($onehot0(onPipe[PIPE_FP_MULT]))
      else $error("fp mult pipe given twice");
   mask_inside_a: assert property ((fwdValid & ~grpMask_reg) == '0)
      else $error("invalid slot forwarded");
   accept_delay_a: assert property (grpValid && grpReady && slotValid != '0 |=>
      !grpReady ##1 fwdValid != '0) else $error("set missing after accept");
   busy_no_ready_a: assert property (fwdValid != '0 |-> !grpReady)
      else $error("ready while set outstanding");
   issued_clears_a: assert property ((fwdValid & issIssued) != '0 |=>
      (fwdValid & $past(fwdValid) & $past(issIssued)) == '0) else $error("issued bit stays");
   unissued_holds_a: assert property ((fwdValid & ~issIssued) != '0 |=>
      fwdValid == ($past(fwdValid) & ~$past(issIssued))) else $error("set changed early");
   bubble_after_a: assert property (fwdValid != '0 && (fwdValid & ~issIssued) == '0 |=>
      fwdValid == '0) else $error("no bubble before next set");

   cover property (grpValid && grpReady);
   cover property (fwdValid == 4'hf);
   cover property (issIssued != '0 && (fwdValid & ~issIssued) != '0);
endmodule // isl_slotter_monitor

bind isl_slotter isl_slotter_monitor i_mon (
   .core_clk  (core_clk),
   .rst_n     (rst_n),
   .grpValid  (grpValid),
   .slotValid (slotValid),
   .grpReady  (grpReady),
   .fwdValid  (fwdValid),
   .fwdPipe   (fwdPipe),
   .issIssued (issIssued)
);

// *** verification/test_instruction_slotting_logic.sv ***
// Testbench for the slotting stage: hand-written groups checked set by set.
// Assumes the issue model answers for the issue stage and the checker is bound.
`timescale 1ns/1ps
`include "isl_params.svh"
module test_instruction_slotting_logic import isl_pkg::*; ;
   logic                  core_clk;
   logic                  rst_n;
   logic                  grpValid;
   logic [`ISL_SLOTS-1:0] slotValid;
   isl_class_t            slotClass [`ISL_SLOTS];
   logic [`ISL_SLOTS-1:0] slotPredTaken;
   logic [`ISL_SLOTS-1:0] slotIprPipeB;
   logic [`ISL_SLOTS-1:0] slotUnalignedQ;
   logic [`ISL_REG_W-1:0] slotDestReg [`ISL_SLOTS];
   logic                  grpReady;
   logic [`ISL_SLOTS-1:0] fwdValid;
   isl_pipe_t             fwdPipe [`ISL_SLOTS];
   logic [`ISL_SLOTS-1:0] issIssued;
   logic                  slowIss;
   int                    n_mismatch;
   int                    tests_run;

   isl_slotter i_dut (.core_clk(core_clk), .rst_n(rst_n), .grpValid(grpValid),
      .slotValid(slotValid), .slotClass(slotClass), .slotPredTaken(slotPredTaken),
      .slotIprPipeB(slotIprPipeB), .slotUnalignedQ(slotUnalignedQ),
      .slotDestReg(slotDestReg), .grpReady(grpReady), .fwdValid(fwdValid),
      .fwdPipe(fwdPipe), .issIssued(issIssued));
   isl_issue_model i_iss (.core_clk(core_clk), .rst_n(rst_n), .slowIss(slowIss),
      .fwdValid(fwdValid), .issIssued(issIssued));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   function automatic logic [15:0] setOf(logic [3:0] v, isl_pipe_t p3, p2, p1, p0);
      return {v, p3, p2, p1, p0};
   endfunction

   task automatic chk_set(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: set %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   // Called just after an edge; values read after an edge are those it sampled
   task automatic offer(input logic [3:0] v, input isl_class_t c0, c1, c2, c3,
                        input logic [3:0] pt, input logic [3:0] ib, input logic [3:0] uq);
      grpValid       <= 1'b1;
      slotValid      <= v;
      slotClass      <= '{c0, c1, c2, c3};
      slotPredTaken  <= pt;
      slotIprPipeB   <= ib;
      slotUnalignedQ <= uq;
      repeat (50) begin
         @(posedge core_clk);
         if (grpReady) break;
      end
      grpValid <= 1'b0;
   endtask

   // Set must show whole, then only shrink until its bubble
   task automatic expect_set(input logic [15:0] exp);
      logic [3:0] seen;
      seen = '0;
      repeat (40) begin
         if (fwdValid != '0) break;
         @(posedge core_clk);
      end
      chk_set({fwdValid, fwdPipe[3], fwdPipe[2], fwdPipe[1], fwdPipe[0]}, exp);
      repeat (40) begin
         if (fwdValid == '0) break;
         seen = seen | fwdValid;
         @(posedge core_clk);
      end
      chk_set({seen, 12'h000}, {exp[15:12], 12'h000});
   endtask

   task automatic expect_done();
      logic [3:0] seen;
      seen = '0;
      repeat (10) begin
         if (grpReady) break;
         seen = seen | fwdValid;
         @(posedge core_clk);
      end
      chk_flag(grpReady, 1'b1);
      chk_set({seen, 12'h000}, 16'h0000);
   endtask

   task automatic t_dual_int();
      offer(4'hf, CLS_IARITH, CLS_SHIFT, CLS_LOAD, CLS_FOP, 4'h0, 4'h0, 4'h0);
      expect_set(setOf(4'h3, PIPE_NONE, PIPE_NONE, PIPE_INT_A, PIPE_INT_B));
      expect_set(setOf(4'hc, PIPE_FP_ADD, PIPE_INT_A, PIPE_NONE, PIPE_NONE));
      expect_done();
   endtask

   task automatic t_ld_st();
      offer(4'hf, CLS_LOAD, CLS_MEMWR, CLS_IARITH, CLS_IARITH, 4'h0, 4'h0, 4'h0);
      expect_set(setOf(4'h1, PIPE_NONE, PIPE_NONE, PIPE_NONE, PIPE_INT_B));
      expect_set(setOf(4'h6, PIPE_NONE, PIPE_INT_B, PIPE_INT_A, PIPE_NONE));
      expect_set(setOf(4'h8, PIPE_INT_A, PIPE_NONE, PIPE_NONE, PIPE_NONE));
      expect_done();
   endtask

   task automatic t_taken();
      offer(4'he, CLS_FOP, CLS_IARITH, CLS_ICBR, CLS_FOP, 4'h4, 4'h0, 4'h0);
      expect_set(setOf(4'h6, PIPE_NONE, PIPE_INT_B, PIPE_INT_A, PIPE_NONE));
      expect_done();
   endtask

   task automatic t_not_taken();
      offer(4'hf, CLS_ICBR, CLS_FCBR, CLS_FMULT, CLS_JUMP, 4'h0, 4'h0, 4'h0);
      expect_set(setOf(4'h1, PIPE_NONE, PIPE_NONE, PIPE_NONE, PIPE_INT_B));
      expect_set(setOf(4'h6, PIPE_NONE, PIPE_FP_MULT, PIPE_FP_ADD, PIPE_NONE));
      expect_set(setOf(4'h8, PIPE_INT_B, PIPE_NONE, PIPE_NONE, PIPE_NONE));
      expect_done();
   endtask

   task automatic t_split_fii();
      slowIss <= 1'b1;
      offer(4'hf, CLS_FOP, CLS_IARITH, CLS_IARITH, CLS_FCOPY, 4'h0, 4'h0, 4'h0);
      expect_set(setOf(4'h3, PIPE_NONE, PIPE_NONE, PIPE_INT_A, PIPE_FP_ADD));
      expect_set(setOf(4'hc, PIPE_FP_ADD, PIPE_INT_A, PIPE_NONE, PIPE_NONE));
      expect_done();
      slowIss <= 1'b0;
   endtask

   task automatic t_split_ifii();
      offer(4'hf, CLS_IARITH, CLS_FCOPY, CLS_ILOGIC, CLS_CMOVE, 4'h0, 4'h0, 4'h0);
      expect_set(setOf(4'h3, PIPE_NONE, PIPE_NONE, PIPE_FP_ADD, PIPE_INT_A));
      expect_set(setOf(4'hc, PIPE_INT_B, PIPE_INT_A, PIPE_NONE, PIPE_NONE));
      expect_done();
   endtask

   task automatic t_null_fp();
      offer(4'hf, CLS_LOAD, CLS_PRMOVE, CLS_FOP, CLS_FCOPY, 4'h0, 4'h2, 4'h1);
      expect_set(setOf(4'hf, PIPE_FP_MULT, PIPE_FP_ADD, PIPE_INT_B, PIPE_NONE));
      expect_done();
      slotDestReg <= '{5'h03, 5'h1f, 5'h1f, 5'h1f};
      offer(4'hf, CLS_LOAD, CLS_PRMOVE, CLS_FOP, CLS_FCOPY, 4'h0, 4'h0, 4'h1);
      expect_set(setOf(4'hf, PIPE_FP_MULT, PIPE_FP_ADD, PIPE_INT_A, PIPE_INT_B));
      expect_done();
   endtask

   initial begin
      n_mismatch     = 0;
      tests_run      = 0;
      rst_n          = 1'b0;
      grpValid       = 1'b0;
      slowIss        = 1'b0;
      slotValid      = 4'h0;
      slotClass      = '{CLS_NULLOP, CLS_NULLOP, CLS_NULLOP, CLS_NULLOP};
      slotPredTaken  = 4'h0;
      slotIprPipeB   = 4'h0;
      slotUnalignedQ = 4'h0;
      slotDestReg    = '{5'h1f, 5'h1f, 5'h1f, 5'h1f};
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      chk_flag(grpReady, 1'b1);
      chk_set({fwdValid, fwdPipe[3], fwdPipe[2], fwdPipe[1], fwdPipe[0]}, 16'h0000);
      t_dual_int();
      t_ld_st();
      t_taken();
      t_not_taken();
      t_split_fii();
      t_split_ifii();
      t_null_fp();
      wrap_up();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      n_mismatch++;
      $display("wrong value at %0t: run did not finish", $time);
      wrap_up();
   end
endmodule // test_instruction_slotting_logic
